// *** verilog/wlp_pkg.sv ***
package wlp_pkg;

	// ****************************************
	// Register map, byte addresses
	// ****************************************
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_WAKE_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_KEY_FIRST = 8'h10;
	localparam logic [7:0] ADDR_KEY_LAST = 8'h3c;
	localparam logic [3:0] KEY_IDX_BASE = 4'h4;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int unsigned BIT_POWER_DOWN = 0;
	localparam int unsigned BIT_WAKE_ENABLE = 0;
	localparam int unsigned BIT_WAKE_MASK = 0;
	localparam int unsigned BIT_WAKE_FLAG = 0;
	localparam int unsigned STATE_LSB = 4;
	localparam logic RESET_POWER_DOWN = 1'b0;
	localparam logic RESET_WAKE_ENABLE = 1'b0;
	localparam logic RESET_WAKE_MASK = 1'b0;
	localparam logic [7:0] RESET_KEY_BYTE = 8'h00;

	// ****************************************
	// Magic packet layout
	// ****************************************
	localparam int unsigned MAC_BYTES = 6;
	localparam int unsigned KEY_BYTES = 12;
	localparam logic [2:0] LAST_HEADER_RUN = 3'h5;
	localparam logic [2:0] LAST_BYTE_IDX = 3'h5;
	localparam logic [3:0] LAST_REPEAT = 4'hf;
	localparam logic [7:0] ALL_ONES_BYTE = 8'hff;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// ****************************************
	// Low-power idle request codes
	// ****************************************
	localparam logic [1:0] SPEED_100 = 2'h1;
	localparam logic [1:0] SPEED_1000 = 2'h2;
	localparam logic [3:0] LPI_CODE_FAST = 4'h1;
	localparam logic [7:0] LPI_CODE_GIG = 8'h01;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLOCK_MHZ = 100;
	localparam int unsigned NEG_IDLE_TIME_US = 1000000;
	localparam int unsigned IDLE_NEG_TIME_US = 2000000;
	localparam int unsigned NEG_IDLE_CYCLES = NEG_IDLE_TIME_US * CLOCK_MHZ;
	localparam int unsigned IDLE_NEG_CYCLES = IDLE_NEG_TIME_US * CLOCK_MHZ;

	typedef enum logic [2:0] {PS_FORCED, PS_NEG, PS_IDLE, PS_DATA, PS_EEE} wlp_power_t;
	typedef enum logic [1:0] {MS_HEADER, MS_ADDRESS, MS_PASSWORD} wlp_match_t;

endpackage

// *** verilog/wlp_key_mem.sv ***
module wlp_key_mem (
	input wire logic clock,
	input wire logic rstn,
	input wire logic wrEn,
	input wire logic [3:0] wrIdx,
	input wire logic [7:0] wrData,
	input wire logic [3:0] rdIdx,
	output logic [7:0] rdData,
	output logic [7:0] keyBytes [wlp_pkg::KEY_BYTES]
);
	import wlp_pkg::*;

	// ****************************************
	// Station address bytes 0..5, password bytes 6..11
	// ****************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < KEY_BYTES; i++) begin
				keyBytes[i] <= RESET_KEY_BYTE;
			end
		end else if (wrEn && (wrIdx < 4'(KEY_BYTES))) begin
			keyBytes[wrIdx] <= wrData;
		end
	end

	// Out-of-range index reads as zero
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdData <= RESET_KEY_BYTE;
		end else if (rdIdx < 4'(KEY_BYTES)) begin
			rdData <= keyBytes[rdIdx];
		end else begin
			rdData <= ZERO_BYTE;
		end
	end

endmodule

// *** verilog/wlp_timer.sv ***
module wlp_timer #(
	parameter int unsigned CYCLES = 16
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic run,
	output logic expired
);
	localparam logic [31:0] LAST_COUNT = 32'(CYCLES - 1);

	logic [31:0] count;

	// Restarts whenever run drops, so each visit gets the full period
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			count <= 32'h0;
			expired <= 1'b0;
		end else if (!run) begin
			count <= 32'h0;
			expired <= 1'b0;
		end else if (count >= LAST_COUNT) begin
			expired <= 1'b1;
		end else begin
			count <= count + 32'h1;
		end
	end

endmodule

// *** verilog/wlp_wake_power.sv ***
// How it works
// - Wake detection works on the byte stream at 10, 100 and 1000 Mbit/s alike.
// - A detected wake packet raises the management interrupt when its mask is set.
// - Six consecutive 0xff bytes form the magic packet header.
// - Header must be followed by the station address sixteen times in a row.
// - The sixteen copies may instead be the all-ones broadcast address.
// - With a password set, six further bytes must equal it; otherwise ignored.
// - An all-zero password means no password check at all.
// - The pattern is found anywhere in the frame, whatever the encapsulation, unless more than six 0xff bytes precede a station address.
// - Host writes six address bytes, byte 0 first; device holds them.
// - Host writes six password bytes, byte 0 first; compared in that order.
// - Setting power-down forces the sleep state from any state.
// - In forced sleep the MAC clocks stop and the line transmitter is silent.
// - Register access keeps working in forced sleep.
// - Forced sleep leaves only on power-down cleared; link dropped on entry.
// - In negotiation, a detected partner brings link-up and the data state.
// - No partner for the negotiation period moves to idle sleep.
// - Idle sleep returns to negotiation on timeout or on partner energy.
// - Data state carries frames and returns to negotiation on link loss.
// - EEE low power is entered and left on MAC idle requests, if negotiated.
module wlp_wake_power #(
	parameter int unsigned NEG_IDLE_CYCLES = wlp_pkg::NEG_IDLE_CYCLES,
	parameter int unsigned IDLE_NEG_CYCLES = wlp_pkg::IDLE_NEG_CYCLES
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [7:0] rxByte,
	input wire logic rxByteValid,
	input wire logic rxFrameActive,
	input wire logic [1:0] txSpeed,
	input wire logic txEn,
	input wire logic txEr,
	input wire logic [7:0] txData,
	input wire logic parallelDetect,
	input wire logic anegComplete,
	input wire logic energyDetect,
	input wire logic linkOk,
	input wire logic eeeNegotiated,
	output logic mgmt_irq_out,
	output logic macClockEnable,
	output logic lineTxEnable,
	output logic linkActive,
	output logic eeeLowPower,
	output wlp_pkg::wlp_power_t powerState
);
	import wlp_pkg::*;

	// ****************************************
	// Register bus
	// ****************************************
	logic busStep;
	logic busDone;
	logic power_down_bit;
	logic wake_detect_enable;
	logic wake_irq_mask;
	logic wakeFlag;
	logic keyHit;
	logic keyWrite;
	logic statusRead;
	logic [3:0] keyIdx;
	logic [7:0] keyRdData;
	logic [7:0] keyBytes [KEY_BYTES];
	logic [31:0] readValue;

	assign busDone = (avs_read || avs_write) && !avs_waitrequest;
	assign keyHit = (avs_address >= ADDR_KEY_FIRST) && (avs_address <= ADDR_KEY_LAST)
		&& (avs_address[1:0] == 2'h0);
	assign keyIdx = avs_address[5:2] - KEY_IDX_BASE;
	assign keyWrite = busDone && avs_write && keyHit && avs_byteenable[0];
	assign statusRead = busDone && avs_read && (avs_address == ADDR_STATUS);

	// Two wait cycles give the key memory time to present registered data
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			busStep <= 1'b0;
			avs_waitrequest <= 1'b1;
		end else if (!avs_waitrequest) begin
			avs_waitrequest <= 1'b1;
		end else if (avs_read || avs_write) begin
			busStep <= !busStep;
			avs_waitrequest <= !busStep;
		end
	end

	always_comb begin
		readValue = 32'h0;
		if (avs_address == ADDR_CONTROL) begin
			readValue[BIT_POWER_DOWN] = power_down_bit;
		end else if (avs_address == ADDR_WAKE_CONTROL) begin
			readValue[BIT_WAKE_ENABLE] = wake_detect_enable;
		end else if (avs_address == ADDR_IRQ_MASK) begin
			readValue[BIT_WAKE_MASK] = wake_irq_mask;
		end else if (avs_address == ADDR_STATUS) begin
			readValue[BIT_WAKE_FLAG] = wakeFlag;
			readValue[STATE_LSB +: 3] = powerState;
		end else if (keyHit) begin
			readValue[7:0] = keyRdData;
		end
	end

	// Unmapped addresses read as zero and ignore writes
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && avs_waitrequest && busStep) begin
			avs_readdata <= readValue;
		end
	end

	// Bus stays live in every power state, sleep included
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			power_down_bit <= RESET_POWER_DOWN;
			wake_detect_enable <= RESET_WAKE_ENABLE;
			wake_irq_mask <= RESET_WAKE_MASK;
		end else if (busDone && avs_write && avs_byteenable[0]) begin
			if (avs_address == ADDR_CONTROL) begin
				power_down_bit <= avs_writedata[BIT_POWER_DOWN];
			end else if (avs_address == ADDR_WAKE_CONTROL) begin
				wake_detect_enable <= avs_writedata[BIT_WAKE_ENABLE];
			end else if (avs_address == ADDR_IRQ_MASK) begin
				wake_irq_mask <= avs_writedata[BIT_WAKE_MASK];
			end
		end
	end

	// Address bytes at 0..5, password bytes at 6..11
	wlp_key_mem keyMem (
		.clock(clock),
		.rstn(rstn),
		.wrEn(keyWrite),
		.wrIdx(keyIdx),
		.wrData(avs_writedata[7:0]),
		.rdIdx(keyIdx),
		.rdData(keyRdData),
		.keyBytes(keyBytes)
	);

	// ****************************************
	// Magic packet matcher
	// ****************************************
	wlp_match_t matchState;
	logic [2:0] ffRun;
	logic [3:0] repCount;
	logic [2:0] byteIdx;
	logic stationOk;
	logic bcastOk;
	logic passwordSet;
	logic stationHit;
	logic bcastHit;
	logic passHit;
	logic isOnes;
	logic wakeHit;

	always_comb begin
		passwordSet = 1'b0;
		for (int i = MAC_BYTES; i < KEY_BYTES; i++) begin
			passwordSet = passwordSet || (keyBytes[i] != ZERO_BYTE);
		end
	end

	assign isOnes = (rxByte == ALL_ONES_BYTE);
	assign stationHit = stationOk && (rxByte == keyBytes[byteIdx]);
	assign bcastHit = bcastOk && isOnes;
	assign passHit = (rxByte == keyBytes[4'(byteIdx) + 4'(MAC_BYTES)]);

	// Byte strobe hides the line rate, so every speed is scanned the same way
	always_comb begin
		wakeHit = 1'b0;
		if (wake_detect_enable && rxFrameActive && rxByteValid) begin
			if (matchState == MS_ADDRESS) begin
				wakeHit = (stationHit || bcastHit) && (byteIdx == LAST_BYTE_IDX)
					&& (repCount == LAST_REPEAT) && !passwordSet;
			end else if (matchState == MS_PASSWORD) begin
				wakeHit = passHit && (byteIdx == LAST_BYTE_IDX);
			end
		end
	end

	// Restarts on any mismatch; a failing 0xff byte may open a new header
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			matchState <= MS_HEADER;
			ffRun <= 3'h0;
			repCount <= 4'h0;
			byteIdx <= 3'h0;
			stationOk <= 1'b0;
			bcastOk <= 1'b0;
		end else if (!wake_detect_enable || !rxFrameActive) begin
			matchState <= MS_HEADER;
			ffRun <= 3'h0;
		end else if (rxByteValid) begin
			case (matchState)
				MS_HEADER: begin
					if (!isOnes) begin
						ffRun <= 3'h0;
					end else if (ffRun == LAST_HEADER_RUN) begin
						matchState <= MS_ADDRESS;
						repCount <= 4'h0;
						byteIdx <= 3'h0;
						stationOk <= 1'b1;
						bcastOk <= 1'b1;
					end else begin
						ffRun <= ffRun + 3'h1;
					end
				end
				MS_ADDRESS: begin
					if (!(stationHit || bcastHit)) begin
						matchState <= MS_HEADER;
						ffRun <= {2'h0, isOnes};
					end else begin
						stationOk <= stationHit;
						bcastOk <= bcastHit;
						if (byteIdx != LAST_BYTE_IDX) begin
							byteIdx <= byteIdx + 3'h1;
						end else begin
							byteIdx <= 3'h0;
							if (repCount != LAST_REPEAT) begin
								repCount <= repCount + 4'h1;
							end else if (passwordSet) begin
								matchState <= MS_PASSWORD;
							end else begin
								matchState <= MS_HEADER;
								ffRun <= 3'h0;
							end
						end
					end
				end
				MS_PASSWORD: begin
					if (!passHit) begin
						matchState <= MS_HEADER;
						ffRun <= {2'h0, isOnes};
					end else if (byteIdx == LAST_BYTE_IDX) begin
						matchState <= MS_HEADER;
						ffRun <= 3'h0;
					end else begin
						byteIdx <= byteIdx + 3'h1;
					end
				end
				default: begin
					matchState <= MS_HEADER;
				end
			endcase
		end
	end

	// ****************************************
	// Wake flag and interrupt
	// ****************************************
	// Set beats a status read in the same cycle; a wake one cycle earlier, as read data is registered, is cleared unread
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wakeFlag <= 1'b0;
		end else if (wakeHit) begin
			wakeFlag <= 1'b1;
		end else if (statusRead) begin
			wakeFlag <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mgmt_irq_out <= 1'b0;
		end else begin
			mgmt_irq_out <= (wakeFlag || wakeHit) && wake_irq_mask;
		end
	end

	// ****************************************
	// Power state controller
	// ****************************************
	wlp_power_t next_powerState;
	logic lpiRequest;
	logic negTimeout;
	logic idleTimeout;

	// 10 Mbit/s has no idle code, so never requests low power
	always_comb begin
		lpiRequest = 1'b0;
		if (!txEn && txEr) begin
			if (txSpeed == SPEED_1000) begin
				lpiRequest = (txData == LPI_CODE_GIG);
			end else if (txSpeed == SPEED_100) begin
				lpiRequest = (txData[3:0] == LPI_CODE_FAST);
			end
		end
	end

	wlp_timer #(
		.CYCLES(NEG_IDLE_CYCLES)
	) negTimer (
		.clock(clock),
		.rstn(rstn),
		.run(powerState == PS_NEG),
		.expired(negTimeout)
	);

	wlp_timer #(
		.CYCLES(IDLE_NEG_CYCLES)
	) idleTimer (
		.clock(clock),
		.rstn(rstn),
		.run(powerState == PS_IDLE),
		.expired(idleTimeout)
	);

	always_comb begin
		next_powerState = powerState;
		if (power_down_bit) begin
			next_powerState = PS_FORCED;
		end else begin
			case (powerState)
				PS_FORCED: begin
					next_powerState = PS_NEG;
				end
				PS_NEG: begin
					if (parallelDetect || anegComplete) begin
						next_powerState = PS_DATA;
					end else if (negTimeout) begin
						next_powerState = PS_IDLE;
					end
				end
				PS_IDLE: begin
					if (energyDetect || idleTimeout) begin
						next_powerState = PS_NEG;
					end
				end
				PS_DATA: begin
					if (!linkOk) begin
						next_powerState = PS_NEG;
					end else if (eeeNegotiated && lpiRequest) begin
						next_powerState = PS_EEE;
					end
				end
				PS_EEE: begin
					if (!linkOk) begin
						next_powerState = PS_NEG;
					end else if (!lpiRequest) begin
						next_powerState = PS_DATA;
					end
				end
				default: begin
					next_powerState = PS_NEG;
				end
			endcase
		end
	end

	// Outputs decoded from the next state so they change with the state itself
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			powerState <= PS_NEG;
			macClockEnable <= 1'b1;
			lineTxEnable <= 1'b1;
			linkActive <= 1'b0;
			eeeLowPower <= 1'b0;
		end else begin
			powerState <= next_powerState;
			macClockEnable <= (next_powerState != PS_FORCED);
			lineTxEnable <= (next_powerState == PS_NEG) || (next_powerState == PS_DATA);
			linkActive <= (next_powerState == PS_DATA) || (next_powerState == PS_EEE);
			eeeLowPower <= (next_powerState == PS_EEE);
		end
	end

endmodule

// *** tb/wlp_wake_power_props.sv ***
module wlp_wake_power_chk #(
	parameter int unsigned NEG_IDLE_CYCLES = 20,
	parameter int unsigned IDLE_NEG_CYCLES = 30
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic parallelDetect,
	input wire logic anegComplete,
	input wire logic energyDetect,
	input wire logic linkOk,
	input wire logic eeeNegotiated,
	input wire logic mgmt_irq_out,
	input wire logic macClockEnable,
	input wire logic lineTxEnable,
	input wire logic linkActive,
	input wire logic eeeLowPower,
	input wire wlp_pkg::wlp_power_t powerState
);
	timeunit 1ns;
	timeprecision 1ps;
	import wlp_pkg::*;
	// ******************
	// Dwell counter
	// ******************
	logic [31:0] runLen;
	wlp_power_t lastState;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			runLen <= '0;
			lastState <= PS_NEG;
		end else begin
			lastState <= powerState;
			runLen <= (powerState == lastState) ? runLen + 1 : '0;
		end
	end
	chk_bus_two_wait:
	assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
		|-> avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait");
	chk_wait_single:
	assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
	chk_forced_quiet:
	assert property (powerState == PS_FORCED |-> !macClockEnable && !lineTxEnable && !linkActive)
		else $error("forced sleep outputs");
	chk_forced_stays:
	assert property (powerState == PS_FORCED && !avs_write && !$past(avs_write)
		|=> powerState == PS_FORCED) else $error("forced sleep left");
	chk_neg_link_up:
	assert property (powerState == PS_NEG && (parallelDetect || anegComplete)
		|=> powerState inside {PS_DATA, PS_FORCED}) else $error("no link-up");
	chk_data_drop:
	assert property (powerState inside {PS_DATA, PS_EEE} && !linkOk
		|=> powerState inside {PS_NEG, PS_FORCED}) else $error("link loss ignored");
	chk_idle_energy:
	assert property (powerState == PS_IDLE && energyDetect
		|=> powerState inside {PS_NEG, PS_FORCED}) else $error("energy ignored");
	chk_eee_gate:
	assert property (powerState == PS_EEE && $past(powerState) == PS_DATA |-> $past(eeeNegotiated))
		else $error("eee without negotiation");
	chk_eee_flags:
	assert property (powerState == PS_EEE |-> eeeLowPower && linkActive && macClockEnable)
		else $error("eee outputs");
	chk_neg_timer:
	assert property (powerState == PS_NEG && lastState == PS_NEG
		|-> runLen <= NEG_IDLE_CYCLES + 2) else $error("negotiation too long");
	chk_idle_timer:
	assert property (powerState == PS_IDLE && lastState == PS_IDLE
		|-> runLen <= IDLE_NEG_CYCLES + 2) else $error("idle too long");
	chk_irq_sticky:
	assert property ($fell(mgmt_irq_out) |-> $past(avs_read || avs_write)
		|| $past(avs_read || avs_write, 2)) else $error("irq dropped alone");
endmodule

bind wlp_wake_power wlp_wake_power_chk #(.NEG_IDLE_CYCLES(NEG_IDLE_CYCLES),
	.IDLE_NEG_CYCLES(IDLE_NEG_CYCLES)) chk (.clock(clock), .rstn(rstn), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .parallelDetect(parallelDetect),
	.anegComplete(anegComplete), .energyDetect(energyDetect), .linkOk(linkOk),
	.eeeNegotiated(eeeNegotiated), .mgmt_irq_out(mgmt_irq_out), .macClockEnable(macClockEnable),
	.lineTxEnable(lineTxEnable), .linkActive(linkActive), .eeeLowPower(eeeLowPower),
	.powerState(powerState));

// *** tb/wlp_mac_model.sv ***
module wlp_mac_model (
	input wire logic clock,
	output logic [7:0] rxByte,
	output logic rxByteValid,
	output logic rxFrameActive,
	output logic txEn,
	output logic txEr,
	output logic [7:0] txData
);
	timeunit 1ns;
	timeprecision 1ps;
	import wlp_pkg::*;
	logic [7:0] pend [$];
	logic slow = 1'b0;
	logic gapTog = 1'b0;
	initial begin
		rxByte = 8'h5a;
		rxByteValid = 1'b0;
		rxFrameActive = 1'b0;
		txEn = 1'b0;
		txEr = 1'b0;
		txData = 8'h00;
	end
	// Idle lane toggles so a stale byte never passes for data
	always @(posedge clock) begin
		gapTog <= ~gapTog;
		rxFrameActive <= pend.size() > 0;
		if (pend.size() > 0 && !(slow && gapTog)) begin
			rxByte <= pend.pop_front();
			rxByteValid <= 1'b1;
		end else begin
			rxByte <= ~rxByte;
			rxByteValid <= 1'b0;
		end
	end
	task automatic sendFrame(input logic [7:0] f [$], input logic s);
		@(negedge clock);
		slow = s;
		pend = f;
		while (pend.size() > 0 || rxFrameActive) begin
			@(posedge clock);
		end
	endtask
	// Upper nibble noise at 100: only [3:0] may count
	task automatic setLpi(input logic on, input logic [1:0] spd);
		@(posedge clock);
		txEn <= 1'b0;
		txEr <= on;
		txData <= !on ? 8'h00 : (spd == SPEED_1000) ? LPI_CODE_GIG : {4'ha, LPI_CODE_FAST};
	endtask
endmodule

// *** tb/wlp_wake_power_test.sv ***
module wlp_wake_power_test;
	timeunit 1ns;
	timeprecision 1ps;
	import wlp_pkg::*;
	localparam int unsigned NEG_T = 20;
	localparam int unsigned IDLE_T = 30;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [7:0] rxByte, txData;
	logic rxByteValid, rxFrameActive, txEn, txEr;
	logic [1:0] txSpeed = 2'h0;
	logic parallelDetect = 1'b0, anegComplete = 1'b0, energyDetect = 1'b0;
	logic linkOk = 1'b0, eeeNegotiated = 1'b0;
	logic mgmt_irq_out, macClockEnable, lineTxEnable, linkActive, eeeLowPower;
	wlp_power_t powerState;
	int errors = 0, check_count = 0, cycles = 0, n;
	logic [31:0] rnd = 32'hf1b2;
	logic [31:0] rd;
	logic [7:0] mac [6], pw [6];
	logic [7:0] frame [$];
	logic maskOn = 1'b0, enOn = 1'b0;
	logic [7:0] regList [6] = '{ADDR_CONTROL, ADDR_WAKE_CONTROL, ADDR_IRQ_MASK, ADDR_KEY_LAST,
		8'h40, 8'h11};
	logic [1:0] spdList [2] = '{SPEED_100, SPEED_1000};
	wlp_wake_power #(.NEG_IDLE_CYCLES(NEG_T), .IDLE_NEG_CYCLES(IDLE_T)) DUT (.clock(clock),
		.rstn(rstn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxByte(rxByte),
		.rxByteValid(rxByteValid), .rxFrameActive(rxFrameActive), .txSpeed(txSpeed),
		.txEn(txEn), .txEr(txEr), .txData(txData), .parallelDetect(parallelDetect),
		.anegComplete(anegComplete), .energyDetect(energyDetect), .linkOk(linkOk),
		.eeeNegotiated(eeeNegotiated), .mgmt_irq_out(mgmt_irq_out),
		.macClockEnable(macClockEnable), .lineTxEnable(lineTxEnable), .linkActive(linkActive),
		.eeeLowPower(eeeLowPower), .powerState(powerState));
	wlp_mac_model partner (.clock(clock), .rxByte(rxByte), .rxByteValid(rxByteValid),
		.rxFrameActive(rxFrameActive), .txEn(txEn), .txEr(txEr), .txData(txData));
	initial begin
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			print_verdict();
		end
	end
	// ******************
	// Helpers and model
	// ******************
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
		@(posedge clock);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do begin
			@(posedge clock);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic waitState(input wlp_power_t s, input int lim, input string what);
		n = 0;
		while (powerState !== s && n < lim) begin
			@(posedge clock);
			n++;
		end
		check(what, s, powerState);
	endtask
	// Scans every start so encapsulation never matters
	function automatic logic hit();
		logic ok, bc, st, pwOn;
		pwOn = 1'b0;
		foreach (pw[k]) pwOn |= pw[k] != ZERO_BYTE;
		for (int s = 0; s + 108 <= frame.size(); s++) begin
			ok = 1'b1;
			bc = 1'b1;
			st = 1'b1;
			for (int k = 0; k < 6; k++) ok &= frame[s + k] == ALL_ONES_BYTE;
			for (int k = 0; k < 96; k++) begin
				bc &= frame[s + 6 + k] == ALL_ONES_BYTE;
				st &= frame[s + 6 + k] == mac[k % 6];
			end
			for (int k = 0; k < 6; k++) ok &= !pwOn || frame[s + 102 + k] == pw[k];
			if (ok && (bc || st)) return 1'b1;
		end
		return 1'b0;
	endfunction
	// Prefix bytes keep bit 7 clear: long 0xff runs before a station address are not found
	task automatic runFrame(input int copies, input logic bc, input logic badPw, input logic s);
		logic exp;
		frame = {};
		repeat (3) begin
			rnd = lfsr(rnd);
			frame.push_back(rnd[7:0] & 8'h7f);
		end
		repeat (6) frame.push_back(ALL_ONES_BYTE);
		for (int i = 0; i < copies * 6; i++) frame.push_back(bc ? ALL_ONES_BYTE : mac[i % 6]);
		for (int i = 0; i < 6; i++) frame.push_back(pw[i] ^ {7'h00, badPw && i == 5});
		frame.push_back(8'h3c);
		exp = hit() && enOn;
		partner.sendFrame(frame, s);
		repeat (3) @(posedge clock);
		check("irq", exp && maskOn, mgmt_irq_out);
		bus(ADDR_STATUS, 1'b0, '0);
		check("wake flag", exp, rd[0]);
		repeat (3) @(posedge clock);
		check("irq cleared", 0, mgmt_irq_out);
		$display("frame test copies %0d done", copies);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ******************
	// Main sequence
	// ******************
	initial begin
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		// Status first, before the negotiation timer moves the state on
		bus(ADDR_STATUS, 1'b0, '0);
		check("status reset", {25'h0, PS_NEG, 4'h0}, rd);
		foreach (regList[i]) begin
			bus(regList[i], 1'b0, '0);
			check("reset value", 0, rd);
		end
		$display("register test done");
		rstn <= 1'b0;
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		waitState(PS_IDLE, NEG_T + 5, "neg to idle");
		check("neg time", 1, n >= NEG_T - 2);
		waitState(PS_NEG, IDLE_T + 5, "idle timeout");
		check("idle time", 1, n >= IDLE_T - 2);
		waitState(PS_IDLE, NEG_T + 5, "idle again");
		energyDetect <= 1'b1;
		waitState(PS_NEG, 3, "energy wake");
		energyDetect <= 1'b0;
		parallelDetect <= 1'b1;
		linkOk <= 1'b1;
		waitState(PS_DATA, 3, "parallel link up");
		check("link active", 1, linkActive);
		check("line tx", 1, lineTxEnable);
		parallelDetect <= 1'b0;
		foreach (spdList[i]) begin
			txSpeed <= spdList[i];
			eeeNegotiated <= 1'b0;
			partner.setLpi(1'b1, spdList[i]);
			repeat (5) @(posedge clock);
			check("no eee", PS_DATA, powerState);
			eeeNegotiated <= 1'b1;
			waitState(PS_EEE, 4, "eee enter");
			check("eee flag", 1, eeeLowPower);
			partner.setLpi(1'b0, spdList[i]);
			waitState(PS_DATA, 4, "eee leave");
		end
		linkOk <= 1'b0;
		waitState(PS_NEG, 3, "link loss");
		anegComplete <= 1'b1;
		linkOk <= 1'b1;
		waitState(PS_DATA, 3, "negotiation_state link up");
		energyDetect <= 1'b1;
		bus(ADDR_CONTROL, 1'b1, 32'h1);
		waitState(PS_FORCED, 3, "forced sleep");
		check("forced outputs", 0, {macClockEnable, lineTxEnable, linkActive});
		repeat (40) @(posedge clock);
		bus(ADDR_STATUS, 1'b0, '0);
		check("status in sleep", PS_FORCED, rd[6:4]);
		anegComplete <= 1'b0;
		energyDetect <= 1'b0;
		bus(ADDR_CONTROL, 1'b1, 32'h0);
		waitState(PS_NEG, 3, "sleep left");
		$display("power test done");
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			mac[i] = rnd[7:0] & 8'h7f;
			pw[i] = ZERO_BYTE;
			bus(ADDR_KEY_FIRST + 8'(4 * i), 1'b1, {24'h0, mac[i]});
			bus(ADDR_KEY_FIRST + 8'(4 * i + 24), 1'b1, 32'h0);
		end
		avs_byteenable <= 4'he;
		bus(ADDR_KEY_FIRST, 1'b1, 32'hff);
		avs_byteenable <= 4'hf;
		bus(ADDR_KEY_FIRST + 8'h14, 1'b0, '0);
		check("address byte 5", mac[5], rd);
		bus(ADDR_KEY_FIRST, 1'b0, '0);
		check("byteenable ignored", mac[0], rd);
		bus(ADDR_IRQ_MASK, 1'b1, 32'h1);
		maskOn = 1'b1;
		bus(ADDR_WAKE_CONTROL, 1'b1, 32'h1);
		enOn = 1'b1;
		for (int s = 0; s < 3; s++) begin
			txSpeed <= 2'(s);
			runFrame(16, 1'b0, 1'b0, s[0]);
		end
		runFrame(15, 1'b0, 1'b0, 1'b0);
		runFrame(16, 1'b1, 1'b0, 1'b1);
		runFrame(16, 1'b0, 1'b1, 1'b0);
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			pw[i] = rnd[7:0] | 8'h01;
			bus(ADDR_KEY_FIRST + 8'(4 * i + 24), 1'b1, {24'h0, pw[i]});
		end
		runFrame(16, 1'b0, 1'b0, 1'b1);
		runFrame(16, 1'b0, 1'b1, 1'b0);
		bus(ADDR_IRQ_MASK, 1'b1, 32'h0);
		maskOn = 1'b0;
		runFrame(16, 1'b0, 1'b0, 1'b0);
		bus(ADDR_WAKE_CONTROL, 1'b1, 32'h0);
		enOn = 1'b0;
		runFrame(16, 1'b0, 1'b0, 1'b0);
		print_verdict();
	end
endmodule
